// ### cusb_cfg.svh
// constants of the co-simulation usb device class logic
`ifndef CUSB_CFG_SVH
`define CUSB_CFG_SVH
// interface descriptor
`define CUSB_LEN_IF 8'h09
`define CUSB_DT_IF 8'h04
`define CUSB_CLASS 8'hFF
`define CUSB_SUBCLASS 8'hCD
`define CUSB_PROTO 8'hCD
`define CUSB_IF_BYTES 5'h09
// class-specific descriptor, identifier in bytes 2..18
`define CUSB_LEN_CLS 8'h09
`define CUSB_DT_CLS 8'h04
`define CUSB_CLS_BYTES 5'h13
`define CUSB_UUID_FIRST 5'h02
`define CUSB_UUID_LAST 5'h12
// endpoint descriptors
`define CUSB_LEN_EP 8'h07
`define CUSB_DT_EP 8'h05
`define CUSB_EP_BYTES 5'h07
`define CUSB_EP_REQ 8'h10
`define CUSB_EP_RSP 8'h21
`define CUSB_ATTR_INT 8'h03
`define CUSB_ATTR_ISO 8'h01
`define CUSB_MPS 16'h0400
`define CUSB_IVAL_CTRL 8'h10
`define CUSB_EP_MIN 4'h3
`define CUSB_DIR_IN 8'h80
// setup decode
`define CUSB_GET_DESC 8'h06
`define CUSB_CLS_REQ 8'h01
`define CUSB_RT_STD 2'h0
`define CUSB_RT_CLASS 2'h1
// fixed pipe slots: request and response pipes come first
`define CUSB_FIXED_EPS 2
`endif

// ### cusb_pkg.sv
// types and shared helpers of the co-simulation usb device class logic
`include "cusb_cfg.svh"
package cusb_pkg;
	typedef enum logic [1:0] {CUSB_IDLE, CUSB_SEND, CUSB_STALL} cusb_ctl_e;
	typedef enum logic [1:0] {CUSB_SEL_IF, CUSB_SEL_CLS, CUSB_SEL_EP} cusb_dsel_e;

	// endpoint address of pipe slot idx; zero for a slot that does not exist
	function automatic logic [7:0] cusb_ep_addr(input logic [7:0] idx, input int nd, input int ni,
		input logic [3:0] base);
		logic [7:0] a;
		a = 8'h00;
		if (idx == 8'h00) begin
			a = `CUSB_EP_REQ;
		end else if (idx == 8'h01) begin
			a = `CUSB_EP_RSP;
		end else if (int'(idx) < nd + `CUSB_FIXED_EPS) begin
			a = {4'h0, base + 4'(int'(idx) - `CUSB_FIXED_EPS)};
		end else if (int'(idx) < nd + ni + `CUSB_FIXED_EPS) begin
			a = `CUSB_DIR_IN | {4'h0, base + 4'(int'(idx) - `CUSB_FIXED_EPS - nd)};
		end
		return a;
	endfunction
endpackage

// ### cusb_desc_rom.sv
// descriptor byte lookup for interface, class-specific and endpoint descriptors
`timescale 1ns/1ns
module cusb_desc_rom #(
	parameter int NUM_DOUT = 1,
	parameter int NUM_DIN = 1,
	parameter logic [7:0] IF_NUM = 8'h00,
	parameter logic [7:0] ALT_SET = 8'h00,
	parameter logic [7:0] STR_IDX = 8'h00,
	parameter logic [135:0] UUID = 136'h0,
	parameter logic [7:0] DATA_ATTR = 8'h03,
	parameter logic [7:0] DATA_IVAL = 8'h01,
	parameter logic [3:0] EP_BASE = 4'h3
) (
	// selection
	input wire cusb_pkg::cusb_dsel_e sel,
	input wire logic [7:0] ep_idx,
	input wire logic [4:0] offset,
	// answer
	output logic [7:0] byte_o,
	output logic [4:0] len_o,
	output logic idx_ok
);
	import cusb_pkg::*;
	localparam logic [7:0] NUM_EPS = 8'(NUM_DOUT + NUM_DIN + `CUSB_FIXED_EPS);
	// bulk or control would break the class, so anything but isochronous falls back to interrupt
	localparam logic [7:0] DATA_TYPE = (DATA_ATTR == `CUSB_ATTR_ISO) ? `CUSB_ATTR_ISO : `CUSB_ATTR_INT;
	// packet size held as a named word so its two bytes can be sliced
	localparam logic [15:0] MPS = `CUSB_MPS;

	wire fixed_ep = (ep_idx < 8'(`CUSB_FIXED_EPS));
	wire [7:0] ep_addr = cusb_ep_addr(ep_idx, NUM_DOUT, NUM_DIN, EP_BASE);
	wire [135:0] uuid_sh = UUID >> (8 * (int'(`CUSB_UUID_LAST) - int'(offset)));
	wire [7:0] if_byte;
	wire [7:0] cls_byte;
	wire [7:0] ep_byte;
	assign idx_ok = (ep_idx < NUM_EPS);

	// interface descriptor: vendor class 255, subclass and protocol 205
	// interface descriptor bytes
	assign if_byte = (offset == 5'h00) ? `CUSB_LEN_IF :
		(offset == 5'h01) ? `CUSB_DT_IF :
		(offset == 5'h02) ? IF_NUM :
		(offset == 5'h03) ? ALT_SET :
		(offset == 5'h04) ? NUM_EPS :
		(offset == 5'h05) ? `CUSB_CLASS :
		(offset == 5'h06) ? `CUSB_SUBCLASS :
		(offset == 5'h07) ? `CUSB_PROTO : STR_IDX;
	// class descriptor keeps length field 9 though identifier runs to byte 18
	// identifier in class descriptor
	assign cls_byte = (offset == 5'h00) ? `CUSB_LEN_CLS :
		(offset == 5'h01) ? `CUSB_DT_CLS : uuid_sh[7:0];
	// endpoint descriptor: fixed pipes are interrupt, 1024 bytes, interval 16
	// fixed and data pipe endpoints
	assign ep_byte = (offset == 5'h00) ? `CUSB_LEN_EP :
		(offset == 5'h01) ? `CUSB_DT_EP :
		(offset == 5'h02) ? ep_addr :
		(offset == 5'h03) ? (fixed_ep ? `CUSB_ATTR_INT : DATA_TYPE) :
		(offset == 5'h04) ? MPS[7:0] :
		(offset == 5'h05) ? MPS[15:8] :
		(fixed_ep ? `CUSB_IVAL_CTRL : DATA_IVAL);

	// output select
	assign byte_o = (sel == CUSB_SEL_IF) ? if_byte : (sel == CUSB_SEL_CLS) ? cls_byte : ep_byte;
	assign len_o = (sel == CUSB_SEL_IF) ? `CUSB_IF_BYTES : (sel == CUSB_SEL_CLS) ? `CUSB_CLS_BYTES : `CUSB_EP_BYTES;
endmodule

// ### cusb_ep_steer.sv
// endpoint address decode to pipe slots for both directions
`timescale 1ns/1ns
module cusb_ep_steer #(
	parameter int NUM_DOUT = 1,
	parameter int NUM_DIN = 1,
	parameter logic [3:0] EP_BASE = 4'h3
) (
	// addresses from the device core
	input wire logic [7:0] out_ep,
	input wire logic [7:0] in_ep,
	// one-hot slot hits: bit 0 the fixed pipe, then data pipes
	output logic [NUM_DOUT:0] out_hit,
	output logic [NUM_DIN:0] in_hit
);
	import cusb_pkg::*;
	// request pipe at slot 0, data-out pipes follow
	// request and response pipe address match
	assign out_hit[0] = (out_ep == `CUSB_EP_REQ);
	assign in_hit[0] = (in_ep == `CUSB_EP_RSP);
	genvar k;
	// data pipes compare against the same address helper the descriptors use
	for (k = 0; k < NUM_DOUT; k++) begin : g_out
		assign out_hit[k + 1] = (out_ep == cusb_ep_addr(8'(k + `CUSB_FIXED_EPS), NUM_DOUT, NUM_DIN, EP_BASE));
	end
	for (k = 0; k < NUM_DIN; k++) begin : g_in
		assign in_hit[k + 1] = (in_ep == cusb_ep_addr(8'(k + NUM_DOUT + `CUSB_FIXED_EPS), NUM_DOUT, NUM_DIN,
			EP_BASE));
	end
endmodule

// ### cusb_dev.sv
// co-simulation usb device class logic behind a usb 2.0 device core
`timescale 1ns/1ns
// Functional notes
// - usb 2.0 link, this end is device
// - control pipe answers standard and class requests
// - request pipe: 0x10, interrupt, 1024, 16
// - response pipe: 0x21, interrupt, 1024, 16
// - data-out pipes take incoming io_data_pdu bytes
// - data-in pipes carry outgoing io_data_pdu bytes
// - pipe counts set by parameters
// - at least one data-in, one data-out
// - one class interface with descriptors
// - interface: 9, 4, 255, 205, 205
// - class descriptor: 9, 4, identifier bytes 2-18
// - data-out endpoint number above 2, out
// - data-in endpoint number above 2, in
// - data endpoints isochronous or interrupt only
module cusb_dev #(
	parameter int NUM_DOUT = 1,
	parameter int NUM_DIN = 1,
	parameter logic [7:0] IF_NUM = 8'h00,
	parameter logic [7:0] ALT_SET = 8'h00,
	parameter logic [7:0] STR_IDX = 8'h00,
	// identifier value is arbitrary
	parameter logic [135:0] UUID = 136'h0102030405060708090A0B0C0D0E0F1011,
	parameter logic [7:0] DATA_ATTR = 8'h03,
	parameter logic [7:0] DATA_IVAL = 8'h01,
	parameter logic [3:0] EP_BASE = 4'h3
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic SRST,
	// setup packets from the device core
	input wire logic SETUP_VALID,
	input wire logic [7:0] SETUP_TYPE,
	input wire logic [7:0] SETUP_REQ,
	input wire logic [15:0] SETUP_VALUE,
	input wire logic [15:0] SETUP_INDEX,
	input wire logic [15:0] SETUP_LENGTH,
	// control data stage toward the core
	output logic CTRL_VALID,
	input wire logic CTRL_READY,
	output logic [7:0] CTRL_DATA,
	output logic CTRL_LAST,
	output logic CTRL_STALL,
	// out packet bytes from the core
	input wire logic OUT_VALID,
	output logic OUT_READY,
	input wire logic [7:0] OUT_EP,
	input wire logic [7:0] OUT_DATA,
	input wire logic OUT_LAST,
	// request pdu stream to the slave
	output logic REQ_VALID,
	input wire logic REQ_READY,
	output logic [7:0] REQ_DATA,
	output logic REQ_LAST,
	// io_data_pdu streams to the slave, one valid per pipe, shared data
	output logic [NUM_DOUT-1:0] DOUT_VALID,
	input wire logic [NUM_DOUT-1:0] DOUT_READY,
	output logic [7:0] DOUT_DATA,
	output logic DOUT_LAST,
	// in packet bytes toward the core
	input wire logic [7:0] IN_EP,
	output logic IN_VALID,
	input wire logic IN_READY,
	output logic [7:0] IN_DATA,
	output logic IN_LAST,
	// response and notification pdu stream from the slave
	input wire logic RSP_VALID,
	output logic RSP_READY,
	input wire logic [7:0] RSP_DATA,
	input wire logic RSP_LAST,
	// io_data_pdu streams from the slave, packed eight bits per pipe
	input wire logic [NUM_DIN-1:0] DIN_VALID,
	output logic [NUM_DIN-1:0] DIN_READY,
	input wire logic [NUM_DIN*8-1:0] DIN_DATA,
	input wire logic [NUM_DIN-1:0] DIN_LAST
);
	import cusb_pkg::*;

	// a class without a data pipe in either direction cannot exchange variables
	// pipe count bounds
	if (NUM_DOUT < 1 || NUM_DIN < 1 || int'(EP_BASE) < int'(`CUSB_EP_MIN) ||
		int'(EP_BASE) + NUM_DOUT > 16 || int'(EP_BASE) + NUM_DIN > 16) begin : g_bad_cfg
		$error("pipe configuration out of range");
	end

	// control state
	cusb_ctl_e state_r, state_nxt;
	cusb_dsel_e sel_r, sel_nxt;
	logic [7:0] idx_r, idx_nxt;
	logic [4:0] off_r, off_nxt;
	logic [4:0] cnt_r, cnt_nxt;
	logic [7:0] byte_r;
	wire [7:0] rom_byte;
	wire [4:0] rom_len;
	wire rom_idx_ok;

	// setup decode
	wire rt_in = SETUP_TYPE[7];
	wire [1:0] rt_kind = SETUP_TYPE[6:5];
	wire [7:0] d_type = SETUP_VALUE[15:8];
	wire [7:0] d_index = SETUP_VALUE[7:0];
	wire std_get = rt_in && (rt_kind == `CUSB_RT_STD) && (SETUP_REQ == `CUSB_GET_DESC);
	wire want_if = std_get && (d_type == `CUSB_DT_IF) && (d_index == 8'h00);
	wire want_ep = std_get && (d_type == `CUSB_DT_EP);
	wire want_cls = rt_in && (rt_kind == `CUSB_RT_CLASS) && (SETUP_REQ == `CUSB_CLS_REQ);
	wire ep_ok = want_ep && rom_idx_ok;
	wire setup_ok = want_if || want_cls || ep_ok;
	wire len_short = (SETUP_LENGTH < {11'h000, rom_len});
	wire [4:0] take_len = len_short ? SETUP_LENGTH[4:0] : rom_len;
	wire ctrl_fire = CTRL_VALID && CTRL_READY;
	wire ctrl_end = (off_r == cnt_r - 5'h01);

	// descriptor lookup runs one step ahead so the data byte is a flop
	cusb_desc_rom #(
		.NUM_DOUT(NUM_DOUT),
		.NUM_DIN(NUM_DIN),
		.IF_NUM(IF_NUM),
		.ALT_SET(ALT_SET),
		.STR_IDX(STR_IDX),
		.UUID(UUID),
		.DATA_ATTR(DATA_ATTR),
		.DATA_IVAL(DATA_IVAL),
		.EP_BASE(EP_BASE)
	) u_rom (
		.sel(sel_nxt),
		.ep_idx(idx_nxt),
		.offset(off_nxt),
		.byte_o(rom_byte),
		.len_o(rom_len),
		.idx_ok(rom_idx_ok)
	);

	// control next state; a new setup always aborts the running data stage
	// control pipe sequencing
	always_comb begin
		state_nxt = state_r;
		sel_nxt = sel_r;
		idx_nxt = idx_r;
		off_nxt = off_r;
		cnt_nxt = cnt_r;
		if (SETUP_VALID) begin
			sel_nxt = want_cls ? CUSB_SEL_CLS : want_ep ? CUSB_SEL_EP : CUSB_SEL_IF;
			idx_nxt = d_index;
			off_nxt = 5'h00;
			cnt_nxt = take_len;
			if (!setup_ok) begin
				state_nxt = CUSB_STALL;
			end else if (take_len == 5'h00) begin
				state_nxt = CUSB_IDLE;
			end else begin
				state_nxt = CUSB_SEND;
			end
		end else begin
			case (state_r)
				CUSB_IDLE: begin
					state_nxt = CUSB_IDLE;
				end
				CUSB_SEND: begin
					if (ctrl_fire) begin
						if (ctrl_end) begin
							state_nxt = CUSB_IDLE;
						end else begin
							off_nxt = off_r + 5'h01;
						end
					end
				end
				CUSB_STALL: begin
					state_nxt = CUSB_IDLE;
				end
				default: begin
					state_nxt = CUSB_IDLE;
				end
			endcase
		end
	end

	// control registers
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			state_r <= CUSB_IDLE;
			sel_r <= CUSB_SEL_IF;
			idx_r <= 8'h00;
			off_r <= 5'h00;
			cnt_r <= 5'h00;
			byte_r <= 8'h00;
		end else begin
			state_r <= state_nxt;
			sel_r <= sel_nxt;
			idx_r <= idx_nxt;
			off_r <= off_nxt;
			cnt_r <= cnt_nxt;
			byte_r <= rom_byte;
		end
	end

	// control data stage outputs
	// descriptor bytes to the host
	assign CTRL_VALID = (state_r == CUSB_SEND);
	assign CTRL_DATA = byte_r;
	assign CTRL_LAST = CTRL_VALID && ctrl_end;
	assign CTRL_STALL = (state_r == CUSB_STALL);

	// pipe address decode
	wire [NUM_DOUT:0] out_hit;
	wire [NUM_DIN:0] in_hit;
	cusb_ep_steer #(
		.NUM_DOUT(NUM_DOUT),
		.NUM_DIN(NUM_DIN),
		.EP_BASE(EP_BASE)
	) u_steer (
		.out_ep(OUT_EP),
		.in_ep(IN_EP),
		.out_hit(out_hit),
		.in_hit(in_hit)
	);

	// out path: one holding byte; bytes for unknown endpoints are swallowed
	logic ov_r;
	logic [7:0] od_r;
	logic ol_r;
	logic [NUM_DOUT:0] osel_r;
	wire o_sink_rdy = |(osel_r & {DOUT_READY, REQ_READY});
	wire o_free = !ov_r || o_sink_rdy;
	wire o_load = OUT_VALID && o_free && (|out_hit);
	assign OUT_READY = o_free;

	// out holding stage
	// device only answers host traffic
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ov_r <= 1'b0;
			od_r <= 8'h00;
			ol_r <= 1'b0;
			osel_r <= '0;
		end else if (o_free) begin
			ov_r <= o_load;
			od_r <= o_load ? OUT_DATA : od_r;
			ol_r <= o_load ? OUT_LAST : ol_r;
			osel_r <= o_load ? out_hit : osel_r;
		end
	end

	// out sinks share one data bus
	// request and io_data_pdu delivery
	assign REQ_VALID = ov_r && osel_r[0];
	assign REQ_DATA = od_r;
	assign REQ_LAST = ol_r;
	assign DOUT_VALID = ov_r ? osel_r[NUM_DOUT:1] : '0;
	assign DOUT_DATA = od_r;
	assign DOUT_LAST = ol_r;

	// in path: a held byte waits for its own endpoint to be polled again
	logic iv_r;
	logic [7:0] id_r;
	logic il_r;
	logic [7:0] iep_r;
	wire [NUM_DIN:0] src_valid = {DIN_VALID, RSP_VALID};
	wire i_take = IN_VALID && IN_READY;
	wire i_free = !iv_r || i_take;
	wire i_load = i_free && (|(in_hit & src_valid));
	logic [7:0] src_data;
	logic src_last;

	// in source select
	// response and data-in source select
	always_comb begin
		src_data = RSP_DATA;
		src_last = RSP_LAST;
		for (int k = 0; k < NUM_DIN; k++) begin
			if (in_hit[k + 1]) begin
				src_data = DIN_DATA[k*8 +: 8];
				src_last = DIN_LAST[k];
			end
		end
	end

	// in holding stage
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			iv_r <= 1'b0;
			id_r <= 8'h00;
			il_r <= 1'b0;
			iep_r <= 8'h00;
		end else if (i_free) begin
			iv_r <= i_load;
			id_r <= i_load ? src_data : id_r;
			il_r <= i_load ? src_last : il_r;
			iep_r <= i_load ? IN_EP : iep_r;
		end
	end

	// in outputs and source back-pressure
	// response and io_data_pdu transmission
	assign IN_VALID = iv_r && (iep_r == IN_EP);
	assign IN_DATA = id_r;
	assign IN_LAST = il_r;
	assign RSP_READY = i_free && in_hit[0];
	assign DIN_READY = i_free ? in_hit[NUM_DIN:1] : '0;
endmodule

// ### cusb_dev_assertions.sv
// port checks of the co-simulation usb device class logic
`timescale 1ns/1ns
module cusb_dev_assertions #(
	parameter int NUM_DOUT = 1,
	parameter int NUM_DIN = 1,
	parameter logic [3:0] EP_BASE = 4'h3
) (
	// clock and reset
	input wire logic REF_CLK,
	input wire logic SRST,
	// setup
	input wire logic SETUP_VALID,
	input wire logic [7:0] SETUP_TYPE,
	input wire logic [7:0] SETUP_REQ,
	input wire logic [15:0] SETUP_VALUE,
	input wire logic [15:0] SETUP_LENGTH,
	// control data stage
	input wire logic CTRL_VALID,
	input wire logic CTRL_READY,
	input wire logic [7:0] CTRL_DATA,
	input wire logic CTRL_LAST,
	input wire logic CTRL_STALL,
	// out path
	input wire logic OUT_VALID,
	input wire logic OUT_READY,
	input wire logic [7:0] OUT_EP,
	input wire logic [7:0] OUT_DATA,
	input wire logic REQ_VALID,
	input wire logic [7:0] REQ_DATA,
	input wire logic [NUM_DOUT-1:0] DOUT_VALID,
	input wire logic [7:0] DOUT_DATA
);
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	// setup decode; a zero wLength gets no answer, so it is left out
	wire setup_in = SETUP_VALID && SETUP_LENGTH != 16'h0000;
	wire std_desc = setup_in && SETUP_TYPE == 8'h80 && SETUP_REQ == 8'h06;
	wire out_take = OUT_VALID && OUT_READY;
	if_answer_a: assert property (std_desc && SETUP_VALUE == 16'h0400 |=> CTRL_VALID && CTRL_DATA == 8'h09)
		else $error("interface answer wrong");
	cls_answer_a: assert property (setup_in && SETUP_TYPE[7] && SETUP_TYPE[6:5] == 2'h1 && SETUP_REQ == 8'h01
		|=> CTRL_VALID && CTRL_DATA == 8'h09) else $error("class answer wrong");
	ep_answer_a: assert property (std_desc && SETUP_VALUE[15:8] == 8'h05
		&& int'(SETUP_VALUE[7:0]) < NUM_DOUT + NUM_DIN + 2 |=> CTRL_VALID && CTRL_DATA == 8'h07) else $error("ep answer wrong");
	bad_stall_a: assert property (setup_in && SETUP_TYPE == 8'h80 && SETUP_REQ != 8'h06 |=> CTRL_STALL && !CTRL_VALID)
		else $error("no stall");
	stall_cause_a: assert property (CTRL_STALL |-> $past(SETUP_VALID)) else $error("stray stall");
	ctrl_hold_a: assert property (CTRL_VALID && !CTRL_READY && !SETUP_VALID
		|=> CTRL_VALID && $stable(CTRL_DATA)) else $error("ctrl byte not held");
	last_valid_a: assert property (CTRL_LAST |-> CTRL_VALID) else $error("last without valid");
	req_route_a: assert property (out_take && OUT_EP == 8'h10 |=> REQ_VALID && REQ_DATA == $past(OUT_DATA))
		else $error("request byte lost");
	dout_route_a: assert property (out_take && OUT_EP == {4'h0, EP_BASE}
		|=> DOUT_VALID[0] && DOUT_DATA == $past(OUT_DATA)) else $error("data-out byte lost");
	// main scenarios reached
	cover property (CTRL_STALL);
	cover property (CTRL_VALID && CTRL_LAST && CTRL_READY);
	cover property (out_take ##1 REQ_VALID);
endmodule
bind cusb_dev cusb_dev_assertions #(.NUM_DOUT(NUM_DOUT), .NUM_DIN(NUM_DIN), .EP_BASE(EP_BASE)) u_check (
	.REF_CLK(REF_CLK), .SRST(SRST), .SETUP_VALID(SETUP_VALID), .SETUP_TYPE(SETUP_TYPE), .SETUP_REQ(SETUP_REQ),
	.SETUP_VALUE(SETUP_VALUE), .SETUP_LENGTH(SETUP_LENGTH), .CTRL_VALID(CTRL_VALID), .CTRL_READY(CTRL_READY),
	.CTRL_DATA(CTRL_DATA), .CTRL_LAST(CTRL_LAST), .CTRL_STALL(CTRL_STALL), .OUT_VALID(OUT_VALID),
	.OUT_READY(OUT_READY), .OUT_EP(OUT_EP), .OUT_DATA(OUT_DATA), .REQ_VALID(REQ_VALID), .REQ_DATA(REQ_DATA),
	.DOUT_VALID(DOUT_VALID), .DOUT_DATA(DOUT_DATA));

// ### cusb_host_model.sv
// host side model: takes control and in bytes, prompt or stalling
`timescale 1ns/1ns
module cusb_host_model (
	// clock and pace
	input wire logic clk,
	input wire logic slow,
	// control data stage
	input wire logic ctrl_valid,
	input wire logic [7:0] ctrl_data,
	input wire logic ctrl_last,
	output logic ctrl_ready,
	// in packets
	input wire logic in_valid,
	input wire logic [7:0] in_data,
	input wire logic in_last,
	output logic in_ready
);
	int seed = 32'h2C9A34B6;
	logic [8:0] ctrl_q[$];
	logic [8:0] in_q[$];
	// host end of link
	// a slow host drops ready about half the time, changed off the sampling edge
	initial begin
		ctrl_ready = 1'b1;
		in_ready = 1'b1;
	end
	always @(negedge clk) begin
		ctrl_ready <= !slow || $random(seed) % 2 == 0;
		in_ready <= !slow || $random(seed) % 2 == 0;
	end
	// every byte the host takes, control bytes with their last flag
	always @(posedge clk) begin
		if (ctrl_valid && ctrl_ready) ctrl_q.push_back({ctrl_last, ctrl_data});
		if (in_valid && in_ready) in_q.push_back({in_last, in_data});
	end
endmodule

// ### cusb_dev_bench.sv
// self-checking bench of the co-simulation usb device class logic
`timescale 1ns/1ns
module cusb_dev_bench;
	localparam int ND = 2;
	localparam int NI = 2;
	// identifier value is arbitrary
	localparam logic [135:0] UID = 136'h11223344556677889900AABBCCDDEEFF12;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic setup_valid = 1'b0;
	logic [7:0] setup_type = 8'h00, setup_req = 8'h00;
	logic [15:0] setup_value = 16'h0000, setup_length = 16'h0000, setup_index = 16'h0000;
	logic ctrl_valid, ctrl_ready, ctrl_last, ctrl_stall, out_ready, req_valid, req_last, dout_last;
	logic in_valid, in_ready, in_last, rsp_ready, stalled;
	logic [7:0] ctrl_data, req_data, dout_data, in_data, d, dst;
	logic [ND-1:0] dout_valid;
	logic [NI-1:0] din_ready;
	logic out_valid = 1'b0, out_last = 1'b0, req_ready = 1'b1, rsp_valid = 1'b0, rsp_last = 1'b0, host_slow = 1'b0;
	logic [7:0] out_ep = 8'h00, out_data = 8'h00, in_ep = 8'h00, rsp_data = 8'h00;
	logic [ND-1:0] dout_ready = '1;
	logic [NI-1:0] din_valid = '0, din_last = '0;
	logic [NI*8-1:0] din_data = '0;
	logic [7:0] eps[4] = '{8'h10, 8'h03, 8'h04, 8'h07};
	logic [7:0] exp_q[$];
	logic [10:0] got[$], want[$];
	int failures = 0;
	int tests_run = 0;
	int seed = 32'h2C9A34B6;
	int p;
	always #20 clk = ~clk;
	cusb_dev #(.NUM_DOUT(ND), .NUM_DIN(NI), .IF_NUM(8'h01), .STR_IDX(8'h02), .UUID(UID),
		.DATA_ATTR(8'h01), .DATA_IVAL(8'h05)) DUT (
		.REF_CLK(clk), .SRST(srst), .SETUP_VALID(setup_valid), .SETUP_TYPE(setup_type), .SETUP_REQ(setup_req),
		.SETUP_VALUE(setup_value), .SETUP_INDEX(setup_index), .SETUP_LENGTH(setup_length),
		.CTRL_VALID(ctrl_valid), .CTRL_READY(ctrl_ready), .CTRL_DATA(ctrl_data), .CTRL_LAST(ctrl_last),
		.CTRL_STALL(ctrl_stall), .OUT_VALID(out_valid), .OUT_READY(out_ready), .OUT_EP(out_ep),
		.OUT_DATA(out_data), .OUT_LAST(out_last), .REQ_VALID(req_valid), .REQ_READY(req_ready),
		.REQ_DATA(req_data), .REQ_LAST(req_last), .DOUT_VALID(dout_valid), .DOUT_READY(dout_ready),
		.DOUT_DATA(dout_data), .DOUT_LAST(dout_last), .IN_EP(in_ep), .IN_VALID(in_valid), .IN_READY(in_ready),
		.IN_DATA(in_data), .IN_LAST(in_last), .RSP_VALID(rsp_valid), .RSP_READY(rsp_ready), .RSP_DATA(rsp_data),
		.RSP_LAST(rsp_last), .DIN_VALID(din_valid), .DIN_READY(din_ready), .DIN_DATA(din_data), .DIN_LAST(din_last));
	cusb_host_model host (.clk(clk), .slow(host_slow), .ctrl_valid(ctrl_valid), .ctrl_data(ctrl_data),
		.ctrl_last(ctrl_last), .ctrl_ready(ctrl_ready), .in_valid(in_valid), .in_data(in_data), .in_last(in_last),
		.in_ready(in_ready));
	// slave sinks stall at random so the holding stage is exercised
	always @(negedge clk) begin
		req_ready <= $random(seed) % 3 != 0;
		dout_ready <= ND'($random(seed));
	end
	// what the slave side takes from the out path, tagged by sink
	always @(posedge clk) begin
		if (req_valid && req_ready) got.push_back({2'h0, req_last, req_data});
		for (int k = 0; k < ND; k++) if (dout_valid[k] && dout_ready[k]) got.push_back({2'(k + 1), dout_last, dout_data});
	end
	// byte i of the endpoint descriptor of slot s
	function automatic logic [7:0] ep_byte(input int s, input int i);
		logic [7:0] a;
		logic [7:0] t[7];
		a = s == 0 ? 8'h10 : s == 1 ? 8'h21 : s < ND + 2 ? 8'(s + 1) : 8'h80 | 8'(s + 1 - ND);
		t = '{8'h07, 8'h05, a, s < 2 ? 8'h03 : 8'h01, 8'h00, 8'h04, s < 2 ? 8'h10 : 8'h05};
		return t[i];
	endfunction
	task automatic finish_test();
		$display("checks %0d, mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic give_up();
		failures++;
		finish_test();
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// one setup, then wait for the last byte or a stall; zero wLength simply times out
	task automatic ctrl(input logic [7:0] t, input logic [7:0] r, input logic [15:0] v, input logic [15:0] l);
		@(negedge clk);
		host.ctrl_q.delete();
		setup_type = t;
		setup_req = r;
		setup_value = v;
		setup_length = l;
		// wIndex is ignored by the design, so any value must do
		setup_index = 16'($random(seed));
		setup_valid = 1'b1;
		@(negedge clk);
		setup_valid = 1'b0;
		stalled = ctrl_stall;
		for (int k = 0; k < 60 && !stalled; k++) begin
			@(negedge clk);
			if (host.ctrl_q.size() > 0 && host.ctrl_q[$][8]) break;
		end
	endtask
	task automatic cmp_ctrl(input int n);
		check("ctrl count", host.ctrl_q.size(), n);
		for (int k = 0; k < n; k++) check("ctrl byte", host.ctrl_q[k], {k == n - 1, exp_q[k]});
	endtask
	// out byte held until the edge that finds out_ready high
	task automatic out_send(input logic [7:0] ep, input logic [7:0] b);
		int k;
		out_ep = ep;
		out_data = b;
		out_last = b[0];
		out_valid = 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (out_ready) break;
		end
		if (ep != 8'h07) want.push_back({ep == 8'h10 ? 2'h0 : 2'(ep - 8'h02), b[0], b});
		@(negedge clk);
		out_valid = 1'b0;
		if (k == 50) give_up();
	endtask
	// slave source p (0 response, else data-in) offers one byte with its endpoint selected
	task automatic src_send(input int sp, input logic [7:0] b);
		int k;
		int n;
		n = host.in_q.size();
		in_ep = sp == 0 ? 8'h21 : 8'h83 + 8'(sp - 1);
		rsp_data = b;
		rsp_last = b[7];
		rsp_valid = sp == 0;
		din_data = {NI{b}};
		din_last = {NI{b[7]}};
		din_valid = sp == 0 ? '0 : NI'(1 << (sp - 1));
		for (k = 0; k < 50; k++) begin
			@(posedge clk);
			if (sp == 0 ? rsp_ready : din_ready[sp - 1]) break;
		end
		@(negedge clk);
		rsp_valid = 1'b0;
		din_valid = '0;
		for (int j = 0; j < 50 && host.in_q.size() == n; j++) @(negedge clk);
		if (k == 50 || host.in_q.size() == n) give_up();
	endtask
	initial begin
		repeat (2) @(negedge clk);
		srst = 1'b0;
		check("reset outs", {ctrl_valid, ctrl_stall, req_valid, dout_valid, in_valid, out_ready}, 7'h01);
		for (int m = 0; m < 2; m++) begin
			host_slow = m[0];
			exp_q = '{8'h09, 8'h04, 8'h01, 8'h00, 8'h06, 8'hFF, 8'hCD, 8'hCD, 8'h02};
			ctrl(8'h80, 8'h06, 16'h0400, 16'h0040);
			cmp_ctrl(9);
			exp_q = '{8'h09, 8'h04};
			for (int k = 0; k < 17; k++) exp_q.push_back(UID[135 - 8 * k -: 8]);
			ctrl(8'hA1, 8'h01, 16'h0000, 16'h00FF);
			cmp_ctrl(19);
			for (int s = 0; s < ND + NI + 2; s++) begin
				exp_q.delete();
				for (int i = 0; i < 7; i++) exp_q.push_back(ep_byte(s, i));
				ctrl(8'h80, 8'h06, {8'h05, 8'(s)}, 16'h0040);
				cmp_ctrl(7);
			end
		end
		exp_q = '{8'h09, 8'h04, 8'h01};
		ctrl(8'h80, 8'h06, 16'h0400, 16'h0003);
		cmp_ctrl(3);
		ctrl(8'h80, 8'h06, 16'h0400, 16'h0000);
		cmp_ctrl(0);
		ctrl(8'h80, 8'h06, 16'h0506, 16'h0040);
		check("stall", stalled, 1'b1);
		ctrl(8'h80, 8'($unsigned($random(seed)) % 6), 16'h0100, 16'h0040);
		check("stall", stalled, 1'b1);
		// in bytes reach the host, which relays each to an out endpoint
		for (int n = 0; n < 24; n++) begin
			p = $unsigned($random(seed)) % 3;
			d = 8'($random(seed));
			src_send(p, d);
			check("in byte", host.in_q[$], {d[7], d});
			dst = eps[$unsigned($random(seed)) % 4];
			out_send(dst, host.in_q[$][7:0]);
		end
		for (int k = 0; k < 100 && got.size() < want.size(); k++) @(negedge clk);
		check("out count", got.size(), want.size());
		foreach (want[k]) check("out byte", got[k], want[k]);
		finish_test();
	end
endmodule
